// file: mcm_coef_table.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Partial product table, one page per coefficient slot
// ****************************************************************
module mcm_coef_table
  import mcm_pkg::*;
#(
  parameter int       SLOT_W   = DEF_PICK_BITS,
  parameter int       DIG_W    = 4,
  parameter int       ENT_W    = 12,
  parameter mcm_ram_t RAM_TYPE = MCM_RAM_AUTO
) (
  input wire logic sys_clk,
  mcm_tab_if.mem   tab
);
  localparam int              DEPTH   = (1 << SLOT_W) * (1 << DIG_W);
  localparam logic [DIG_W-1:0] CF_ADDR = DIG_W'(COEF_ENTRY);

  // Block type is not used here; behaviour is the same for both
  logic [ENT_W-1:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (tab.wr_en) begin
      mem_q[{tab.wr_slot, tab.wr_addr}] <= tab.wr_data;
    end
  end

  assign tab.rd_data = mem_q[{tab.rd_slot, tab.rd_addr}];
  assign tab.cf_data = mem_q[{tab.rd_slot, CF_ADDR}];
endmodule
`default_nettype wire

// file: mcm_mult.sv
`timescale 1ns/1ps
`default_nettype none
module mcm_mult
  import mcm_pkg::*;
#(
  parameter int       DATA_W       = DEF_DATA_W,
  parameter int       COEF_W       = DEF_COEF_W,
  parameter bit       DATA_SIGNED  = 1'b0,
  parameter bit       COEF_SIGNED  = 1'b0,
  parameter int       INIT_COEF    = DEF_INIT_COEF,
  parameter int       PICK_BITS    = DEF_PICK_BITS,
  parameter bit       LOAD_EN      = 1'b1,
  parameter bit       SCLR_EN      = 1'b1,
  parameter mcm_ram_t RAM_TYPE     = MCM_RAM_AUTO,
  parameter int       CYCLES_LIMIT = DEF_CYCLES,
  parameter int       PROD_W       = DEF_PROD_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic [DATA_W-1:0]    operand_in,
  input  wire logic                 operand_load_strobe,
  input  wire logic [PICK_BITS-1:0] coefficient_pick,
  input  wire logic [COEF_W-1:0]    coefficient_input,
  input  wire logic                 coefficient_write_strobe,
  input  wire logic                 sync_clear,
  output logic      [PROD_W-1:0]    product,
  output logic                      product_valid,
  output logic                      coefficient_loaded
);
  // ****************************************************************
  // Derived geometry
  // ****************************************************************
  // One operand digit is looked up per cycle, so the digit width
  // trades table depth against the cycle budget
  localparam int DIG_W    = (DATA_W + CYCLES_LIMIT - 1) / CYCLES_LIMIT;
  localparam int PAD_W    = DIG_W * CYCLES_LIMIT;
  localparam int ENT_W    = COEF_W + DIG_W;
  localparam int ACC_W    = PAD_W + COEF_W;
  localparam int SH_W     = $clog2(PAD_W + 1);
  localparam int CNT_W    = $clog2(CYCLES_LIMIT + 1);
  localparam int DEPTH    = 1 << DIG_W;
  localparam int LOAD_LAT = DEPTH;
  localparam int LAT      = CYCLES_LIMIT - 1;

  localparam logic [DIG_W-1:0]     IDX_LAST  = DIG_W'(DEPTH - 1);
  localparam logic [PICK_BITS-1:0] SLOT_LAST = {PICK_BITS{1'b1}};
  localparam logic [CNT_W-1:0]     CNT_LAST  = CNT_W'(CYCLES_LIMIT - 1);
  localparam logic [SH_W-1:0]      SH_STEP   = SH_W'(DIG_W);

  // ****************************************************************
  // Build checks
  // ****************************************************************
  if (!mcm_data_w_ok(DATA_W)) begin : g_bad_data_w
    $error("operand width not supported");
  end
  if (!mcm_coef_w_ok(COEF_W)) begin : g_bad_coef_w
    $error("coefficient width not supported");
  end
  if (INIT_COEF < INIT_COEF_MIN || INIT_COEF > INIT_COEF_MAX) begin : g_bad_ic
    $error("initial coefficient out of range");
  end
  if (CYCLES_LIMIT < 1 || CYCLES_LIMIT > DATA_W ||
      DIG_W > DIGIT_W_MAX) begin : g_bad_lim
    $error("cycle limit cannot be served for this operand width");
  end
  if (PICK_BITS < 1 || PICK_BITS > PICK_BITS_MAX) begin : g_bad_pick
    $error("pick width not supported");
  end
  if (PROD_W < 1 || PROD_W > ACC_W) begin : g_bad_prod
    $error("product width not supported");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [ENT_W-1:0] coef_ext(input logic [COEF_W-1:0] c);
    return COEF_SIGNED ? ENT_W'(signed'(c)) : ENT_W'(c);
  endfunction

  function automatic logic [PAD_W-1:0] opnd_ext(input logic [DATA_W-1:0] d);
    return DATA_SIGNED ? PAD_W'(signed'(d)) : PAD_W'(d);
  endfunction

  // Preset slot s holds the first fixed coefficient plus s
  function automatic logic [COEF_W-1:0] preset(input int s);
    return COEF_W'(INIT_COEF + s);
  endfunction

  localparam logic [ENT_W-1:0] INIT_STEP = coef_ext(preset(0));

  mcm_tab_if #(.SLOT_W(PICK_BITS), .DIG_W(DIG_W), .ENT_W(ENT_W)) tab ();

  mcm_coef_table #(
    .SLOT_W   (PICK_BITS),
    .DIG_W    (DIG_W),
    .ENT_W    (ENT_W),
    .RAM_TYPE (RAM_TYPE)
  ) u_table (
    .sys_clk (sys_clk),
    .tab     (tab.mem)
  );

  // ****************************************************************
  // Coefficient loader
  // ****************************************************************
  mcm_ld_state_t          ld_state_q;
  logic [PICK_BITS-1:0]   ld_slot_q;
  logic [DIG_W-1:0]       ld_idx_q;
  logic [ENT_W-1:0]       ld_val_q;
  logic [ENT_W-1:0]       ld_step_q;
  logic                   ld_all_q;
  logic                   init_done_q;
  logic                   load_acc;

  // Strobes arriving mid rewrite are dropped, not queued
  assign load_acc = LOAD_EN && coefficient_write_strobe &&
                    coefficient_loaded;
  assign coefficient_loaded = (ld_state_q == LD_IDLE);

  // Entries are built by repeated addition, entry k = k * coefficient
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_state_q  <= LD_FILL;
      ld_all_q    <= 1'b1;
      ld_slot_q   <= '0;
      ld_idx_q    <= '0;
      ld_val_q    <= '0;
      ld_step_q   <= INIT_STEP;
      init_done_q <= 1'b0;
    end else begin
      case (ld_state_q)
        LD_IDLE: begin
          if (load_acc) begin
            ld_state_q <= LD_FILL;
            ld_slot_q  <= coefficient_pick;
            ld_idx_q   <= '0;
            ld_val_q   <= '0;
            ld_step_q  <= coef_ext(coefficient_input);
          end
        end
        LD_FILL: begin
          ld_idx_q <= ld_idx_q + DIG_W'(1);
          ld_val_q <= ld_val_q + ld_step_q;
          if (ld_idx_q == IDX_LAST) begin
            ld_val_q <= '0;
            if (ld_all_q && ld_slot_q != SLOT_LAST) begin
              ld_slot_q <= ld_slot_q + PICK_BITS'(1);
              ld_step_q <= coef_ext(preset(int'(ld_slot_q) + 1));
            end else begin
              ld_state_q  <= LD_IDLE;
              ld_all_q    <= 1'b0;
              init_done_q <= 1'b1;
            end
          end
        end
        default: begin
          ld_state_q <= LD_IDLE;
        end
      endcase
    end
  end

  assign tab.wr_en   = (ld_state_q == LD_FILL);
  assign tab.wr_slot = ld_slot_q;
  assign tab.wr_addr = ld_idx_q;
  assign tab.wr_data = ld_val_q;

  // ****************************************************************
  // Digit serial engine
  // ****************************************************************
  logic                 busy_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [SH_W-1:0]      sh_q;
  logic [PAD_W-1:0]     opnd_q;
  logic [ACC_W-1:0]     acc_q;
  logic [PICK_BITS-1:0] slot_q;
  logic                 neg_q;
  logic [PROD_W-1:0]    product_q;
  logic                 valid_q;
  logic                 clr_eff;
  logic                 start_eff;
  logic                 fin;
  logic                 last;
  logic                 neg_now;
  logic [PAD_W-1:0]     in_ext;
  logic [PAD_W-1:0]     opnd_src;
  logic [ACC_W-1:0]     base;
  logic [SH_W-1:0]      shamt;
  logic [CNT_W-1:0]     cnt_now;
  logic [PICK_BITS-1:0] slot_rd;
  logic [ACC_W-1:0]     step_sum;
  logic [ACC_W-1:0]     corr;
  logic [ACC_W-1:0]     final_sum;

  assign clr_eff   = SCLR_EN && sync_clear;
  // With a one cycle budget the strobe is not looked at
  assign start_eff = init_done_q && !clr_eff &&
                     (CYCLES_LIMIT == 1 || operand_load_strobe);
  assign in_ext    = opnd_ext(operand_in);

  // A start takes its first digit straight from the operand pins
  always_comb begin
    if (start_eff) begin
      opnd_src = in_ext;
      base     = '0;
      shamt    = '0;
      cnt_now  = '0;
      slot_rd  = coefficient_pick;
      neg_now  = DATA_SIGNED && in_ext[PAD_W-1];
    end else begin
      opnd_src = opnd_q;
      base     = acc_q;
      shamt    = sh_q;
      cnt_now  = cnt_q;
      slot_rd  = slot_q;
      neg_now  = neg_q;
    end
    last = (cnt_now == CNT_LAST);
    fin  = (start_eff || busy_q) && !clr_eff && last;
  end

  // Signed operand: the top digit weighs negative, so take back c*2^PAD_W
  assign corr      = neg_now ? {tab.cf_data[COEF_W-1:0], {PAD_W{1'b0}}} : '0;
  assign final_sum = step_sum - corr;

  assign tab.rd_slot = slot_rd;
  assign tab.rd_addr = opnd_src[DIG_W-1:0];

  mcm_shift_add #(
    .ENT_W      (ENT_W),
    .ACC_W      (ACC_W),
    .SH_W       (SH_W),
    .SIGNED_ENT (COEF_SIGNED)
  ) u_add (
    .acc_in (base),
    .entry  (tab.rd_data),
    .shamt  (shamt),
    .sum    (step_sum)
  );

  // A slot rewritten while in use mixes old and new entries; callers
  // should not reload the slot that a running product reads
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      sh_q   <= '0;
      opnd_q <= '0;
      acc_q  <= '0;
      slot_q <= '0;
      neg_q  <= 1'b0;
    end else if (clr_eff) begin
      busy_q <= 1'b0;
    end else if (start_eff || busy_q) begin
      opnd_q <= opnd_src >> DIG_W;
      acc_q  <= step_sum;
      cnt_q  <= CNT_W'(cnt_now + CNT_W'(1));
      sh_q   <= SH_W'(shamt + SH_STEP);
      slot_q <= slot_rd;
      neg_q  <= neg_now;
      busy_q <= !last;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      product_q <= '0;
      valid_q   <= 1'b0;
    end else if (clr_eff) begin
      valid_q <= 1'b0;
    end else if (fin) begin
      product_q <= final_sum[PROD_W-1:0];
      valid_q   <= 1'b1;
    end else if (start_eff) begin
      valid_q <= 1'b0;
    end
  end

  assign product       = product_q;
  assign product_valid = valid_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  done_in_time_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    start_eff |-> ##[0:LAT] (fin || clr_eff || $past(start_eff) && start_eff))
  else $error("product not finished within the cycle limit");

  result_hold_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !fin |=> $stable(product))
  else $error("product changed without a finished multiplication");

  clear_valid_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    clr_eff |=> !product_valid && !busy_q)
  else $error("clear did not drop valid and abandon work");

  clear_keeps_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    clr_eff && coefficient_loaded && !load_acc |=> coefficient_loaded)
  else $error("clear disturbed the coefficient table");

  load_busy_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    load_acc |=> !coefficient_loaded ##LOAD_LAT coefficient_loaded)
  else $error("coefficient load length wrong");

  load_refused_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    coefficient_write_strobe && !coefficient_loaded && !ld_all_q &&
    ld_idx_q != IDX_LAST |=> $stable(ld_slot_q) && $stable(ld_step_q))
  else $error("load accepted while a load was running");

  pick_slot_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    start_eff |=> slot_q == $past(coefficient_pick))
  else $error("wrong coefficient slot captured");

  restart_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    start_eff && busy_q && CYCLES_LIMIT > 1 |=> busy_q && cnt_q == 1)
  else $error("running product not abandoned on restart");

  valid_cause_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(product_valid) |-> $past(fin))
  else $error("valid rose without a finished product");

  every_clock_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    init_done_q && !clr_eff && CYCLES_LIMIT == 1 |=> product_valid)
  else $error("single cycle mode missed a product");

endmodule
`default_nettype wire

// file: mcm_mult_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcm_mult_tb
  import mcm_pkg::*;
;
  localparam int DW = 8;
  localparam int CW = 8;
  localparam int PB = 1;
  localparam int PW = 16;

  logic          sys_clk;
  logic          reset_n;
  logic [DW-1:0] opnd;
  logic          op_stb;
  logic [PB-1:0] pick;
  logic [CW-1:0] cin;
  logic          c_stb;
  logic          sclr;
  logic [PW-1:0] prod;
  logic          prod_v;
  logic          ld;
  logic [PW-1:0] prod1;
  logic          prod1_v;
  logic          ld1;
  logic [PW-1:0] prods;
  logic          prods_v;
  logic          lds;
  int            fail_count;
  int            n_checks;
  logic [CW-1:0] coef_m [2**PB];
  logic [PW-1:0] held;
  int            cnt;

  // ****************************************************************
  // Clock, design and user model
  // ****************************************************************
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  mcm_mult i_mcm_mult (.sys_clk(sys_clk), .reset_n(reset_n),
    .operand_in(opnd), .operand_load_strobe(op_stb),
    .coefficient_pick(pick), .coefficient_input(cin),
    .coefficient_write_strobe(c_stb), .sync_clear(sclr), .product(prod),
    .product_valid(prod_v), .coefficient_loaded(ld));

  // One-cycle build shares every input with the main one; clear built out
  mcm_mult #(.CYCLES_LIMIT(1), .SCLR_EN(1'b0)) i_mcm_mult_c1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n), .operand_in(opnd), .operand_load_strobe(op_stb),
    .coefficient_pick(pick), .coefficient_input(cin),
    .coefficient_write_strobe(c_stb), .sync_clear(sclr), .product(prod1),
    .product_valid(prod1_v), .coefficient_loaded(ld1));

  // Signed build sees the same traffic, so both signedness options run
  mcm_mult #(.DATA_SIGNED(1'b1), .COEF_SIGNED(1'b1)) i_mcm_mult_s (
    .sys_clk(sys_clk), .reset_n(reset_n), .operand_in(opnd),
    .operand_load_strobe(op_stb), .coefficient_pick(pick),
    .coefficient_input(cin), .coefficient_write_strobe(c_stb),
    .sync_clear(sclr), .product(prods), .product_valid(prods_v),
    .coefficient_loaded(lds));

  mcm_user_model i_mcm_user_model (.sys_clk(sys_clk),
    .loaded_all(ld & ld1 & lds), .operand_in(opnd),
    .operand_load_strobe(op_stb),
    .coefficient_pick(pick), .coefficient_input(cin),
    .coefficient_write_strobe(c_stb), .sync_clear(sclr));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  function automatic logic [PW-1:0] exp_prod(input logic [DW-1:0] a,
                                             input logic [PB-1:0] p);
    logic [DW+CW-1:0] f;
    f = a * coef_m[p];
    return f[PW-1:0];
  endfunction

  function automatic logic [PW-1:0] exp_sprod(input logic [DW-1:0] a,
                                              input logic [PB-1:0] p);
    logic signed [DW+CW-1:0] f;
    f = $signed(a) * $signed(coef_m[p]);
    return f[PW-1:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic mul_chk(input logic [DW-1:0] a, input logic [PB-1:0] p);
    i_mcm_user_model.start(a, p, 1'b0);
    check(32'(prod_v), 32'h0);
    @(negedge sys_clk);
    check(32'(prod), 32'(exp_prod(a, p)));
    check(32'(prod_v), 32'h1);
    check(32'(prod1), 32'(exp_prod(a, p)));
    check(32'(prod1_v), 32'h1);
    check(32'(prods), 32'(exp_sprod(a, p)));
    check(32'(prods_v), 32'h1);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [CW-1:0] k;
    logic [PB-1:0] p;
    fail_count = 0;
    n_checks   = 0;
    reset_n    = 1'b0;
    void'($urandom(32'hc960));
    for (int s = 0; s < 2**PB; s++) coef_m[s] = CW'(DEF_INIT_COEF + s);
    repeat (2) @(negedge sys_clk);
    check({prod_v, ld, prod}, 32'h0);
    reset_n = 1'b1;
    // Start during the preset fill is refused
    i_mcm_user_model.start(8'h5a, 1'b1, 1'b0);
    @(negedge sys_clk);
    check(32'(prod_v), 32'h0);
    cnt = 0;
    while ((ld & ld1) !== 1'b1 && cnt < 1000) begin
      @(negedge sys_clk);
      cnt++;
    end
    check(32'(ld & ld1), 32'h1);
    for (int s = 0; s < 2**PB; s++) mul_chk(8'hff, PB'(s));
    // Load with a refused strobe while the rewrite runs
    k = 8'hc3;
    i_mcm_user_model.load(1'b1, k, 0);
    check(32'(ld), 32'h0);
    // A gap cycle keeps the strobe from being raised as it is dropped
    @(negedge sys_clk);
    i_mcm_user_model.force_load(1'b1, 8'h11);
    cnt = 3;
    while (ld !== 1'b1 && cnt < 40) begin
      @(negedge sys_clk);
      cnt++;
    end
    check(32'(cnt), 32'h11);
    coef_m[1] = k;
    i_mcm_user_model.load(1'b0, 8'h00, 0);
    i_mcm_user_model.load(1'b0, 8'h07, 0);
    coef_m[0] = 8'h07;
    while ((ld & ld1) !== 1'b1) @(negedge sys_clk);
    mul_chk(8'hff, 1'b1);
    mul_chk(8'h80, 1'b0);
    // Back to back: second start abandons the first
    i_mcm_user_model.start(8'h33, 1'b1, 1'b1);
    mul_chk(8'h02, 1'b1);
    // Product stands while the operand moves without a start
    held = prod;
    repeat (4) i_mcm_user_model.wiggle(DW'($urandom));
    check({15'h0, prod_v, prod}, {16'h1, held});
    // Clear during a running product
    i_mcm_user_model.start(8'h44, 1'b0, 1'b0);
    i_mcm_user_model.clear();
    check({15'h0, prod_v, prod}, {16'h0, held});
    check(32'(prod1_v), 32'h1);
    repeat (3) @(negedge sys_clk);
    check(32'(prod_v), 32'h0);
    mul_chk(8'h44, 1'b1);
    // Random mix of loads and products, slow and prompt
    for (int i = 0; i < 40; i++) begin
      p = PB'($urandom);
      if ($urandom_range(3) == 0) begin
        k = CW'($urandom);
        i_mcm_user_model.load(p, k, $urandom_range(3));
        coef_m[p] = k;
        while ((ld & ld1) !== 1'b1) @(negedge sys_clk);
      end else begin
        mul_chk(DW'($urandom), p);
      end
    end
    mul_chk(8'hff, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// file: mcm_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants and types
// ****************************************************************
package mcm_pkg;

  localparam int DEF_DATA_W    = 8;
  localparam int DEF_COEF_W    = 8;
  localparam int DEF_CYCLES    = 2;
  localparam int DEF_PICK_BITS = 1;
  localparam int DEF_PROD_W    = 16;
  localparam int DEF_INIT_COEF = 0;
  localparam int INIT_COEF_MIN = 0;
  localparam int INIT_COEF_MAX = 4;
  localparam int DIGIT_W_MAX   = 8;
  localparam int PICK_BITS_MAX = 8;
  localparam int COEF_ENTRY    = 1;
  localparam int W_SMALL_MIN   = 2;
  localparam int W_SMALL_MAX   = 8;
  localparam int W_MID         = 16;
  localparam int W_WIDE        = 24;
  localparam int W_WIDEST      = 32;

  typedef enum logic [0:0] {
    MCM_RAM_AUTO     = 1'b0,
    MCM_RAM_EMBEDDED = 1'b1
  } mcm_ram_t;

  typedef enum logic [0:0] {
    LD_IDLE = 1'b0,
    LD_FILL = 1'b1
  } mcm_ld_state_t;

  function automatic bit mcm_coef_w_ok(input int w);
    return (w >= W_SMALL_MIN && w <= W_SMALL_MAX) || w == W_MID ||
           w == W_WIDE;
  endfunction

  function automatic bit mcm_data_w_ok(input int w);
    return mcm_coef_w_ok(w) || w == W_WIDEST;
  endfunction

endpackage
`default_nettype wire

// file: mcm_shift_add.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Aligned accumulate of one table entry
// ****************************************************************
module mcm_shift_add
  import mcm_pkg::*;
#(
  parameter int ENT_W      = 12,
  parameter int ACC_W      = 16,
  parameter int SH_W       = 4,
  parameter bit SIGNED_ENT = 1'b0
) (
  input  wire logic [ACC_W-1:0] acc_in,
  input  wire logic [ENT_W-1:0] entry,
  input  wire logic [SH_W-1:0]  shamt,
  output logic      [ACC_W-1:0] sum
);
  logic [ACC_W-1:0] ext;

  always_comb begin
    ext = SIGNED_ENT ? ACC_W'(signed'(entry)) : ACC_W'(entry);
    sum = acc_in + (ext << shamt);
  end
endmodule
`default_nettype wire

// file: mcm_tab_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Coefficient table access
// ****************************************************************
interface mcm_tab_if #(
  parameter int SLOT_W = 1,
  parameter int DIG_W  = 4,
  parameter int ENT_W  = 12
) ();
  logic              wr_en;
  logic [SLOT_W-1:0] wr_slot;
  logic [DIG_W-1:0]  wr_addr;
  logic [ENT_W-1:0]  wr_data;
  logic [SLOT_W-1:0] rd_slot;
  logic [DIG_W-1:0]  rd_addr;
  logic [ENT_W-1:0]  rd_data;
  logic [ENT_W-1:0]  cf_data;

  modport ctrl (output wr_en, wr_slot, wr_addr, wr_data, rd_slot, rd_addr,
                input  rd_data, cf_data);
  modport mem  (input  wr_en, wr_slot, wr_addr, wr_data, rd_slot, rd_addr,
                output rd_data, cf_data);
endinterface
`default_nettype wire

// file: mcm_user_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// User logic feeding operands and coefficients
// ****************************************************************
module mcm_user_model
  import mcm_pkg::*;
#(
  parameter int DATA_W    = DEF_DATA_W,
  parameter int COEF_W    = DEF_COEF_W,
  parameter int PICK_BITS = DEF_PICK_BITS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 loaded_all,
  output logic      [DATA_W-1:0]    operand_in,
  output logic                      operand_load_strobe,
  output logic      [PICK_BITS-1:0] coefficient_pick,
  output logic      [COEF_W-1:0]    coefficient_input,
  output logic                      coefficient_write_strobe,
  output logic                      sync_clear
);
  initial begin
    operand_in               = '0;
    operand_load_strobe      = 1'b0;
    coefficient_pick         = '0;
    coefficient_input        = '0;
    coefficient_write_strobe = 1'b0;
    sync_clear               = 1'b0;
  end

  // All tasks are entered just after a falling edge
  // Operand and pick are held after the pulse, so a one-cycle build
  // keeps multiplying the same value
  task automatic start(input logic [DATA_W-1:0] a,
                       input logic [PICK_BITS-1:0] p, input bit keep);
    operand_in          = a;
    coefficient_pick    = p;
    operand_load_strobe = 1'b1;
    @(negedge sys_clk);
    if (!keep) operand_load_strobe = 1'b0;
  endtask

  // Slow users idle for gap cycles before the strobe
  task automatic load(input logic [PICK_BITS-1:0] p,
                      input logic [COEF_W-1:0] k, input int gap);
    repeat (gap) @(negedge sys_clk);
    while (loaded_all !== 1'b1) @(negedge sys_clk);
    force_load(p, k);
  endtask

  // Strobe without waiting; load calls it after its wait, and the main sequence calls it directly to provoke a refusal
  task automatic force_load(input logic [PICK_BITS-1:0] p,
                            input logic [COEF_W-1:0] k);
    coefficient_pick         = p;
    coefficient_input        = k;
    coefficient_write_strobe = 1'b1;
    @(negedge sys_clk);
    coefficient_write_strobe = 1'b0;
    // Data is no longer held, so a stale value cannot pass for a match
    coefficient_input        = ~k;
  endtask

  task automatic clear();
    sync_clear = 1'b1;
    @(negedge sys_clk);
    sync_clear = 1'b0;
  endtask

  task automatic wiggle(input logic [DATA_W-1:0] a);
    operand_in = a;
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire
